// ===== rtl/cptd_top.sv
// call progress tone detector with apb register access
// assumes signed 16-bit voice samples in pclk domain, one per sample tick
// Operation
// - band-pass the input to 300..650 Hz before measuring energy
// - control bit 7 enables detection; cleared means detection is off
// - control bits 3..0 set averaging time constant, larger is slower
// - set flag bit 0 when average energy exceeds the on threshold
// - flag reads 0 below off threshold unless above on threshold, and from one clock after enable is cleared
// - clear flag when average energy falls below the off threshold and does not exceed the on threshold
// - thresholds are 16-bit two's complement fractions of full scale
// - energy register reports instantaneous in-band power 0..0xFFFF
`timescale 1ns/1ps
module cptd_top
  import cptd_pkg::*;
#(
  parameter int W         = 16,
  parameter int SAMPLE_DIV = CPTD_SAMPLE_DIV
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [13:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output      logic [31:0]  prdata,
  output      logic         pready,
  output      logic         pslverr,
  // voice samples
  input  wire logic [W-1:0] sample_in,
  // detection result
  output      logic         tone_detected_flag
);

  // register state
  cptd_ctrl_s  ctrl_reg;
  logic [15:0] on_thr_reg;
  logic [15:0] off_thr_reg;
  logic        flag_reg, flag_next;
  logic [31:0] prdata_next;
  cptd_bus_e   bus_reg;

  // sample rate divider
  logic [15:0] div_reg;
  logic        tick_reg;
  logic        sample_en;

  // datapath
  logic signed [W-1:0] filt;
  logic [W-1:0]        power;
  logic [W-1:0]        average;
  logic                clear;

  // apb decode
  wire setup     = psel && !penable;
  wire hit_ctrl  = (paddr == CPTD_ADDR_CTRL);
  wire hit_flags = (paddr == CPTD_ADDR_FLAGS);
  wire hit_on    = (paddr == CPTD_ADDR_ON_THR);
  wire hit_off   = (paddr == CPTD_ADDR_OFF_THR);
  wire hit_nrg   = (paddr == CPTD_ADDR_ENERGY);
  wire mapped    = hit_ctrl || hit_flags || hit_on || hit_off || hit_nrg;
  // read-only registers refuse writes with an error
  wire ro_write  = pwrite && (hit_flags || hit_nrg);
  wire bad       = !mapped || ro_write;
  // writes land at the edge that completes the access phase
  wire wr_ok     = psel && penable && pready && pwrite && mapped && !ro_write;
  wire wr_ctrl   = wr_ok && hit_ctrl && pstrb[0];
  wire wr_on_lo  = wr_ok && hit_on && pstrb[0];
  wire wr_on_hi  = wr_ok && hit_on && pstrb[1];
  wire wr_off_lo = wr_ok && hit_off && pstrb[0];
  wire wr_off_hi = wr_ok && hit_off && pstrb[1];

  wire [7:0] ctrl_byte = {ctrl_reg.enable, 3'b000, ctrl_reg.tconst};
  wire [7:0] flag_byte = {7'b0000000, flag_reg};

  assign prdata_next =
    (!pwrite && hit_ctrl)  ? {24'h000000, ctrl_byte} :
    (!pwrite && hit_flags) ? {24'h000000, flag_byte} :
    (!pwrite && hit_on)    ? {16'h0000, on_thr_reg}  :
    (!pwrite && hit_off)   ? {16'h0000, off_thr_reg} :
    (!pwrite && hit_nrg)   ? {16'h0000, power}       :
                             32'h00000000;

  // detection stays quiet and the filter is flushed while disabled
  assign clear     = !ctrl_reg.enable;
  assign sample_en = tick_reg;

  // signed compare of average against signed thresholds: average is never
  // negative, so a negative threshold always counts as exceeded
  wire signed [16:0] avg_s = {1'b0, average};
  wire signed [16:0] on_s  = {on_thr_reg[15], on_thr_reg};
  wire signed [16:0] off_s = {off_thr_reg[15], off_thr_reg};
  wire above_on  = avg_s > on_s;
  wire below_off = avg_s < off_s;

  always_comb begin
    flag_next = flag_reg;
    if (!ctrl_reg.enable) begin
      flag_next = 1'b0;
    end else if (above_on) begin
      flag_next = 1'b1;
    end else if (below_off) begin
      flag_next = 1'b0;
    end
  end

  cptd_bandpass #(
    .W (W)
  ) u_bandpass (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en),
    .clear     (clear),
    .din       ($signed(sample_in)),
    .dout      (filt)
  );

  cptd_energy #(
    .W (W)
  ) u_energy (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en),
    .clear     (clear),
    .tconst    (ctrl_reg.tconst),
    .din       (filt),
    .power     (power),
    .average   (average)
  );

  // sample tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == 16'(SAMPLE_DIV - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // control and threshold registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= cptd_ctrl_s'({CPTD_CTRL_RST[CPTD_EN_BIT],
                                   CPTD_CTRL_RST[CPTD_TC_MSB:0]});
      on_thr_reg  <= CPTD_ON_THR_RST;
      off_thr_reg <= CPTD_OFF_THR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.enable <= pwdata[CPTD_EN_BIT];
        ctrl_reg.tconst <= pwdata[CPTD_TC_MSB:0];
      end
      if (wr_on_lo) on_thr_reg[7:0] <= pwdata[7:0];
      if (wr_on_hi) on_thr_reg[15:8] <= pwdata[15:8];
      if (wr_off_lo) off_thr_reg[7:0] <= pwdata[7:0];
      if (wr_off_hi) off_thr_reg[15:8] <= pwdata[15:8];
    end
  end

  // detection flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg           <= 1'b0;
      tone_detected_flag <= 1'b0;
    end else begin
      flag_reg           <= flag_next;
      tone_detected_flag <= flag_next;
    end
  end

  // apb handshake: one wait-free access phase, answer set at setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reg <= CPTD_BUS_IDLE;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      case (bus_reg)
        CPTD_BUS_IDLE: begin
          if (setup) begin
            bus_reg <= CPTD_BUS_ACCESS;
            prdata  <= prdata_next;
            pready  <= 1'b1;
            pslverr <= bad;
          end
        end
        CPTD_BUS_ACCESS: begin
          bus_reg <= CPTD_BUS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          bus_reg <= CPTD_BUS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

endmodule : cptd_top

// ===== rtl/cptd_pkg.sv
// package for the call progress tone detector
// assumes an apb slave wrapper and a signed 16-bit sample stream
package cptd_pkg;

  // register byte addresses (indices not all contiguous: address is index * 4)
  localparam logic [11:0] CPTD_IDX_CTRL     = 12'h280;
  localparam logic [11:0] CPTD_IDX_FLAGS    = 12'h281;
  localparam logic [11:0] CPTD_IDX_ON_THR   = 12'h282;
  localparam logic [11:0] CPTD_IDX_OFF_THR  = 12'h284;
  localparam logic [11:0] CPTD_IDX_ENERGY   = 12'h286;
  localparam logic [13:0] CPTD_ADDR_CTRL    = {CPTD_IDX_CTRL, 2'b00};
  localparam logic [13:0] CPTD_ADDR_FLAGS   = {CPTD_IDX_FLAGS, 2'b00};
  localparam logic [13:0] CPTD_ADDR_ON_THR  = {CPTD_IDX_ON_THR, 2'b00};
  localparam logic [13:0] CPTD_ADDR_OFF_THR = {CPTD_IDX_OFF_THR, 2'b00};
  localparam logic [13:0] CPTD_ADDR_ENERGY  = {CPTD_IDX_ENERGY, 2'b00};

  // field positions
  localparam int CPTD_EN_BIT   = 7;
  localparam int CPTD_TC_MSB   = 3;
  localparam int CPTD_FLAG_BIT = 0;

  // reset values
  localparam logic [7:0]  CPTD_CTRL_RST    = 8'h07;
  localparam logic [15:0] CPTD_ON_THR_RST  = 16'h2400;
  localparam logic [15:0] CPTD_OFF_THR_RST = 16'h1A00;

  // sample rate of the filter input: one enable per this many clocks
  localparam int CPTD_CLK_HZ    = 100_000_000;
  localparam int CPTD_SAMPLE_HZ = 8_000;
  localparam int CPTD_SAMPLE_DIV = CPTD_CLK_HZ / CPTD_SAMPLE_HZ;

  typedef struct packed {
    logic       enable;
    logic [3:0] tconst;
  } cptd_ctrl_s;

  typedef enum logic [1:0] {
    CPTD_BUS_IDLE   = 2'b01,
    CPTD_BUS_ACCESS = 2'b10
  } cptd_bus_e;

endpackage : cptd_pkg

// ===== rtl/cptd_bandpass.sv
// second order band-pass, about 300 to 650 Hz at an 8 kHz sample rate
// assumes samples arrive with a one-cycle sample_en strobe
`timescale 1ns/1ps
module cptd_bandpass
  import cptd_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // sample stream
  input  wire logic                sample_en,
  input  wire logic                clear,
  input  wire logic signed [W-1:0] din,
  output      logic signed [W-1:0] dout
);
  // coefficients in q2.14: centre ~450 Hz, bandwidth ~350 Hz
  // pole radius ~0.863 keeps a2 well inside the unit circle; b0 sets
  // unity gain at the centre so a full-scale tone cannot saturate
  localparam logic signed [17:0] B0  = 18'sh0085A;
  localparam logic signed [17:0] A1  = 18'sh06795;
  localparam logic signed [17:0] A2N = 18'sh02F9E;

  logic signed [W-1:0] x1_reg, x2_reg, y1_reg, y2_reg;
  logic signed [47:0]  acc;
  logic signed [47:0]  acc_sh;
  logic signed [W-1:0] y_sat;

  // y = b0*(x - x2) + a1*y1 - a2*y2; band edges set by pole radius
  assign acc = B0 * (48'(din) - 48'(x2_reg)) + A1 * 48'(y1_reg)
             - A2N * 48'(y2_reg);
  assign acc_sh = acc >>> 14;
  // saturate so a loud out-of-band burst cannot wrap the energy
  assign y_sat = (acc_sh > 48'sd32767) ? 16'sh7FFF :
                 (acc_sh < -48'sd32768) ? 16'sh8000 : acc_sh[W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x1_reg <= '0;
      x2_reg <= '0;
      y1_reg <= '0;
      y2_reg <= '0;
    end else if (clear) begin
      x1_reg <= '0;
      x2_reg <= '0;
      y1_reg <= '0;
      y2_reg <= '0;
    end else if (sample_en) begin
      x2_reg <= x1_reg;
      x1_reg <= din;
      y2_reg <= y1_reg;
      y1_reg <= y_sat;
    end
  end

  assign dout = y1_reg;
endmodule : cptd_bandpass

// ===== rtl/cptd_energy.sv
// instantaneous power and exponential average of a filtered stream
// assumes one filtered sample per sample_en
`timescale 1ns/1ps
module cptd_energy
  import cptd_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // control
  input  wire logic                sample_en,
  input  wire logic                clear,
  input  wire logic [3:0]          tconst,
  // data
  input  wire logic signed [W-1:0] din,
  output      logic [W-1:0]        power,
  output      logic [W-1:0]        average
);
  logic [2*W-1:0] sq;
  logic [W-1:0]   pw;
  logic [W+15:0]  avg_reg, avg_next;

  // widen before the product so the upper half of the square is kept
  assign sq = (2*W)'(din) * (2*W)'(din);
  // full-scale square lands at 0x4000_0000, so shift twice to use all bits
  assign pw = (sq[2*W-1:2*W-2] != 2'b00) ? 16'hFFFF : sq[2*W-3:W-2];

  // leaky integrator, shift by tc: larger tc means slower response
  assign avg_next = avg_reg - (avg_reg >> tconst)
                  + ({16'h0000, pw} << (5'd16 - 5'(tconst)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_reg <= '0;
      power   <= '0;
    end else if (clear) begin
      avg_reg <= '0;
      power   <= '0;
    end else if (sample_en) begin
      avg_reg <= avg_next;
      power   <= pw;
    end
  end

  assign average = avg_reg[W+15:16];
endmodule : cptd_energy

// ===== dv/cptd_top_assertions.sv
// concurrent checks on the tone detector ports
// assumes zero-wait apb and a flag forced low one clock after disable
`timescale 1ns/1ps
module cptd_top_assertions
  import cptd_pkg::*;
#(
  parameter int W          = 16,
  parameter int SAMPLE_DIV = CPTD_SAMPLE_DIV
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // result
  input wire logic        tone_detected_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // shadow of the control fields, updated where the write takes effect
  logic       en_reg;
  logic [3:0] tc_reg;
  wire        ctrl_w  = pready && psel && penable && pwrite
                        && paddr == CPTD_ADDR_CTRL;
  wire        rd_done = pready && psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
      tc_reg <= CPTD_CTRL_RST[3:0];
    end else if (ctrl_w) begin
      en_reg <= pwdata[CPTD_EN_BIT];
      tc_reg <= pwdata[3:0];
    end
  end
  property p_ready_timing; psel && !penable |=> pready && penable; endproperty
  a_ready_timing: assert property (p_ready_timing)
    else $error("no answer one cycle after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held too long");
  property p_ro_refused;
    pready && pwrite && (paddr == CPTD_ADDR_FLAGS || paddr == CPTD_ADDR_ENERGY)
      |-> pslverr;
  endproperty
  a_ro_refused: assert property (p_ro_refused)
    else $error("write to read-only register accepted");
  property p_energy_width;
    rd_done && paddr == CPTD_ADDR_ENERGY |-> prdata[31:16] == 16'h0000;
  endproperty
  a_energy_width: assert property (p_energy_width)
    else $error("energy read wider than 16 bits");
  property p_flag_status;
    rd_done && paddr == CPTD_ADDR_FLAGS
      |-> prdata == {31'h0, $past(tone_detected_flag)};
  endproperty
  a_flag_status: assert property (p_flag_status)
    else $error("status read differs from flag");
  property p_off_forces; !en_reg && !$past(en_reg) |-> !tone_detected_flag;
  endproperty
  a_off_forces: assert property (p_off_forces)
    else $error("flag set while disabled");
  property p_rise_needs_en; $rose(tone_detected_flag) |-> en_reg; endproperty
  a_rise_needs_en: assert property (p_rise_needs_en)
    else $error("flag rose without enable");
  property p_ctrl_readback;
    rd_done && paddr == CPTD_ADDR_CTRL
      |-> prdata[7] == en_reg && prdata[3:0] == tc_reg;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control readback wrong");
endmodule : cptd_top_assertions

bind cptd_top cptd_top_assertions #(.W(W), .SAMPLE_DIV(SAMPLE_DIV))
  i_cptd_top_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tone_detected_flag(tone_detected_flag));

// ===== dv/tb_top.sv
// self-checking bench: apb tasks and a sine source per sample tick
// assumes zero-wait apb and a shortened sample divider
`timescale 1ns/1ps
module tb_top;
  import cptd_pkg::*;
  localparam int DIV = 4;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [13:0] paddr   = 14'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [15:0] sample_in = 16'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        flag;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          sc = 0;
  int          t0;
  int          t6;
  real         amp = 0.0;
  real         freq = 450.0;
  real         ph = 0.0;
  cptd_top #(.W(16), .SAMPLE_DIV(DIV)) i_cptd_top (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .tone_detected_flag(flag));
  always #5 pclk = ~pclk;
  // sample held a whole tick so the design's tick phase does not matter
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sc = (sc + 1) % DIV;
    if (sc == 0) begin
      ph = ph + freq / 8000.0;
      sample_in <= 16'($rtoi(amp * $sin(6.2831853 * ph)));
    end
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk
  task automatic wait_s(input int n);
    repeat (n * DIV) @(posedge pclk);
    #1;
  endtask : wait_s
  task automatic detect(input logic [3:0] tc, output int t);
    amp = 0.0;
    apb(1'b1, CPTD_ADDR_CTRL, 32'h00);
    apb(1'b1, CPTD_ADDR_CTRL, {24'h0, 4'h8, tc});
    amp = 16384.0;
    t = 0;
    while (flag !== 1'b1 && t < 2000) begin
      wait_s(1);
      t++;
    end
  endtask : detect
  task automatic t_regs;
    rd_chk(CPTD_ADDR_CTRL, 32'h07);
    rd_chk(CPTD_ADDR_FLAGS, 32'h0);
    rd_chk(CPTD_ADDR_ON_THR, 32'h2400);
    rd_chk(CPTD_ADDR_OFF_THR, 32'h1A00);
    apb(1'b1, CPTD_ADDR_ENERGY, 32'h1234);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CPTD_ADDR_FLAGS, 32'h1);
    rd_chk(CPTD_ADDR_FLAGS, 32'h0);
    rd_chk(CPTD_ADDR_ENERGY, 32'h0);
    apb(1'b0, 14'h0A0C, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask : t_regs
  // negative on threshold: an unsigned compare would never set the flag
  task automatic t_signed;
    apb(1'b1, CPTD_ADDR_ON_THR, 32'hFFFF);
    apb(1'b1, CPTD_ADDR_OFF_THR, 32'h8000);
    apb(1'b1, CPTD_ADDR_CTRL, 32'h80);
    wait_s(8);
    chk({31'h0, flag}, 32'h1);
    rd_chk(CPTD_ADDR_FLAGS, 32'h1);
    apb(1'b1, CPTD_ADDR_CTRL, 32'h00);
    wait_s(1);
    chk({31'h0, flag}, 32'h0);
  endtask : t_signed
  task automatic t_tone;
    apb(1'b1, CPTD_ADDR_ON_THR, 32'h0C00);
    apb(1'b1, CPTD_ADDR_OFF_THR, 32'h0400);
    // slow averaging: with tc 0 the flag follows the sine's own ripple
    apb(1'b1, CPTD_ADDR_CTRL, 32'h87);
    amp = 16384.0;
    wait_s(600);
    chk({31'h0, flag}, 32'h1);
    apb(1'b0, CPTD_ADDR_ENERGY, 32'h0);
    chk({31'h0, rd[15:0] != 16'h0}, 32'h1);
    apb(1'b1, CPTD_ADDR_ON_THR, 32'h7FFF);
    wait_s(50);
    chk({31'h0, flag}, 32'h1);
    apb(1'b1, CPTD_ADDR_OFF_THR, 32'h7FF0);
    wait_s(8);
    chk({31'h0, flag}, 32'h0);
    apb(1'b1, CPTD_ADDR_ON_THR, 32'h0C00);
    apb(1'b1, CPTD_ADDR_OFF_THR, 32'h0400);
    amp = 0.0;
    wait_s(600);
    chk({31'h0, flag}, 32'h0);
    freq = 3000.0;
    amp = 16384.0;
    wait_s(600);
    chk({31'h0, flag}, 32'h0);
    freq = 450.0;
  endtask : t_tone
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_signed();
    t_tone();
    detect(4'h0, t0);
    detect(4'h6, t6);
    chk({31'h0, flag}, 32'h1);
    chk({31'h0, t6 > t0}, 32'h1);
    summarize();
  end
endmodule : tb_top
